//--- icd_pkg.sv
// Shared constants and types for the bridge command decoder
package icd_pkg;

  // Command codes carried on the host byte stream
  localparam logic [7:0] CMD_DEV_RESET = 8'hF0;
  localparam logic [7:0] CMD_SET_PTR = 8'hE1;
  localparam logic [7:0] CMD_WR_CFG = 8'hD2;
  localparam logic [7:0] CMD_LINE_RESET = 8'hB4;
  localparam logic [7:0] CMD_LINE_BIT = 8'h87;

  // Pointer codes that may follow the set-pointer command
  localparam logic [7:0] PTR_CODE_STATUS = 8'hF0;
  localparam logic [7:0] PTR_CODE_DATA = 8'hE1;
  localparam logic [7:0] PTR_CODE_CFG = 8'hC3;

  // Bit positions in the status_flags register
  localparam int ST_BUSY = 0;
  localparam int ST_PRES = 1;
  localparam int ST_SHORT = 2;
  localparam int ST_LEVEL = 3;
  localparam int ST_RST = 4;
  localparam int ST_SBR = 5;
  localparam int ST_TSB = 6;
  localparam int ST_DIR = 7;
  localparam logic [7:0] STATUS_RESET = 8'h10;

  // Bit positions in the bus_configuration register (low nibble)
  localparam int CFG_ACTIVE = 0;
  localparam int CFG_SPARE = 1;
  localparam int CFG_STRONG = 2;
  localparam int CFG_OVERDRIVE = 3;
  localparam logic [3:0] CFG_RESET = 4'h0;
  localparam logic [3:0] CFG_UPPER_READ = 4'h0;

  // Bit counter: eight data bits, then the acknowledge slot
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_STEP = 4'h1;
  localparam logic [3:0] BIT_ACK = 4'h8;

  // Timing figures and their cycle counts at the system clock
  localparam int CLK_PERIOD_PS = 100000;
  localparam int RESET_DONE_PS = 525000;
  localparam int LINE_STOP_PS = 262500;
  localparam int RESET_DONE_CYC = (RESET_DONE_PS / CLK_PERIOD_PS) < 1 ?
                                  1 : (RESET_DONE_PS / CLK_PERIOD_PS);
  localparam int LINE_STOP_CYC = (LINE_STOP_PS / CLK_PERIOD_PS) < 1 ?
                                 1 : (LINE_STOP_PS / CLK_PERIOD_PS);

  typedef enum logic [1:0] {
    ICD_PTR_STATUS = 2'b00,
    ICD_PTR_DATA = 2'b01,
    ICD_PTR_CFG = 2'b10
  } icd_ptr_t;

  typedef enum logic [1:0] {
    ICD_PH_CODE = 2'b00,
    ICD_PH_PARAM = 2'b01,
    ICD_PH_IGNORE = 2'b10
  } icd_phase_t;

endpackage

//--- icd_cmd_decoder.sv
// Host command decoder: byte intake on the link clock, registers on mclk
//
// Overview of operation
// RL1: Each command moves pointer to relevant register
// RL2: Ack accepted bytes, withhold ack on invalid
// RL3: Pointer codes F0h status, E1h data, C3h config
// RL4: Code F0h resets state and aborts line
// RL5: Device reset accepted anytime, never refused; the code leaves it unacked after a refused code byte in the same frame
// RL6: Device reset completes within 525 ns
// RL7: Line activity stops within 262.5 ns
// RL8: After device reset pointer selects status
// RL9: Reset sets reset flag, clears result flags
// RL10: Reset clears overdrive, active, strong pullup bits
// RL11: Set-pointer overrides pointer of running command
// RL12: Invalid pointer code: no ack, command ignored
// RL13: Pointer changes at ack; line unaffected
// RL14: Code D2h writes configuration, no line activity
// RL15: Config accepted only if upper nibble complements lower
// RL16: Config read back has upper nibble zero
// RL17: Busy at config code: nack code and parameter
// RL18: Config register updates at byte ack
// RL19: Config write selects config, clears reset flag
// RL20: Busy flag high while line operation runs
// RL21: Strong pullup bit clears when pullup ends
// RL22: Line commands and parameters go to engine
`timescale 1ns/10ps
module icd_cmd_decoder
  import icd_pkg::*;
#(
  parameter logic [7:0] CODE_WR_BYTE = 8'h11,
  parameter logic [7:0] CODE_RD_BYTE = 8'h22,
  parameter logic [7:0] CODE_TRIPLET = 8'h33
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic link_clk,
  input wire logic link_frame,
  input wire logic link_bit,
  output logic sda_out,
  output logic sda_oe_n,
  output icd_ptr_t read_ptr,
  output logic [7:0] read_byte,
  output logic line_busy_flag,
  output logic overdrive_select,
  output logic active_pullup_enable,
  output logic strong_pullup_enable,
  output logic eng_start,
  output logic [7:0] eng_cmd,
  output logic [7:0] eng_param,
  output logic eng_abort,
  input wire logic eng_done,
  input wire logic eng_reset_upd,
  input wire logic eng_presence,
  input wire logic eng_short,
  input wire logic eng_bit_upd,
  input wire logic eng_bit,
  input wire logic eng_trip_upd,
  input wire logic eng_trip_second,
  input wire logic eng_trip_dir,
  input wire logic eng_data_valid,
  input wire logic [7:0] eng_data,
  input wire logic eng_spu_end,
  input wire logic line_level_raw
);

  localparam int STOP_MAX = LINE_STOP_CYC;
  localparam int DONE_MAX = RESET_DONE_CYC;

  // Codes handled by the line sequencing engine
  function automatic logic is_engine(input logic [7:0] code);
    is_engine = (code == CMD_LINE_RESET) || (code == CMD_LINE_BIT) ||
                (code == CODE_WR_BYTE) || (code == CODE_RD_BYTE) ||
                (code == CODE_TRIPLET);
  endfunction

  // Codes that are followed by one parameter byte
  function automatic logic takes_param(input logic [7:0] code);
    takes_param = (code == CMD_SET_PTR) || (code == CMD_WR_CFG) ||
                  (code == CMD_LINE_BIT) || (code == CODE_WR_BYTE) ||
                  (code == CODE_TRIPLET);
  endfunction

  // ---------------- Link clock domain ----------------
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] cmd_reg;
  logic [7:0] ev_cmd_reg;
  logic [7:0] ev_par_reg;
  logic ev_tgl_reg;
  logic sda_oe_n_reg;
  logic busy_l1_reg;
  logic busy_l2_reg;
  icd_phase_t phase_reg;
  icd_phase_t phase_next;

  // Byte decode for the acknowledge decision
  wire ack_slot = (bit_cnt_reg == BIT_ACK);
  wire ptr_code_ok = (shift_reg == PTR_CODE_STATUS) || // RL12
                     (shift_reg == PTR_CODE_DATA) ||
                     (shift_reg == PTR_CODE_CFG);
  wire cfg_byte_ok = (shift_reg[7:4] == ~shift_reg[3:0]); // RL15
  wire code_free = (shift_reg == CMD_DEV_RESET) || (shift_reg == CMD_SET_PTR);
  wire code_gated = (shift_reg == CMD_WR_CFG) || is_engine(shift_reg);
  wire code_ok = code_free || (code_gated && !busy_l2_reg); // RL17
  wire param_ok = (cmd_reg == CMD_SET_PTR) ? ptr_code_ok :
                  (cmd_reg == CMD_WR_CFG) ? cfg_byte_ok : 1'b1;
  wire ack_ok = (phase_reg == ICD_PH_CODE) ? code_ok :
                (phase_reg == ICD_PH_PARAM) ? param_ok : 1'b0;
  wire want_param = takes_param(shift_reg);
  wire post_now = ack_slot && ack_ok &&
                  ((phase_reg == ICD_PH_PARAM) || !want_param);

  // Phase after the acknowledge slot; a refused code byte mutes the frame, a refused parameter returns to code
  always_comb begin
    phase_next = ICD_PH_CODE;
    if (!ack_ok) begin
      phase_next = (phase_reg == ICD_PH_PARAM) ? ICD_PH_CODE : ICD_PH_IGNORE;
    end else if (phase_reg == ICD_PH_CODE && want_param) begin
      phase_next = ICD_PH_PARAM;
    end
  end

  // Bit intake; frame low between frames restarts at a command code
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt_reg <= BIT_FIRST;
      shift_reg <= 8'h00;
      phase_reg <= ICD_PH_CODE;
    end else if (!link_frame) begin
      bit_cnt_reg <= BIT_FIRST;
      phase_reg <= ICD_PH_CODE;
    end else if (!ack_slot) begin
      shift_reg <= {shift_reg[6:0], link_bit};
      bit_cnt_reg <= bit_cnt_reg + BIT_STEP;
    end else begin
      bit_cnt_reg <= BIT_FIRST;
      phase_reg <= phase_next;
    end
  end

  // Command code kept for its parameter byte
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_reg <= 8'h00;
    end else if (link_frame && ack_slot && phase_reg == ICD_PH_CODE) begin
      cmd_reg <= shift_reg;
    end
  end

  // Finished command posted at the rising edge of its ack bit
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      ev_cmd_reg <= 8'h00;
      ev_par_reg <= 8'h00;
      ev_tgl_reg <= 1'b0;
    end else if (link_frame && post_now) begin // RL13 RL18 RL22
      ev_cmd_reg <= (phase_reg == ICD_PH_CODE) ? shift_reg : cmd_reg;
      ev_par_reg <= shift_reg;
      ev_tgl_reg <= ~ev_tgl_reg;
    end
  end

  // Ack driven from the falling edge, held through the ack slot
  always_ff @(negedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      sda_oe_n_reg <= 1'b1;
    end else begin
      sda_oe_n_reg <= !(link_frame && ack_slot && ack_ok); // RL2
    end
  end

  // Busy flag brought over; may lag a freshly started command
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_l1_reg <= 1'b0;
      busy_l2_reg <= 1'b0;
    end else begin
      busy_l1_reg <= line_busy_flag;
      busy_l2_reg <= busy_l1_reg;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_n = sda_oe_n_reg;

  // ---------------- System clock domain ----------------
  logic tgl_s1_reg;
  logic tgl_s2_reg;
  logic tgl_s3_reg;
  logic lvl_s1_reg;
  logic lvl_s2_reg;
  icd_ptr_t ptr_reg;
  icd_ptr_t ptr_next;
  logic [7:0] status_reg;
  logic [7:0] status_next;
  logic [3:0] cfg_reg;
  logic [3:0] cfg_next;
  logic [7:0] data_reg;
  logic [7:0] read_byte_reg;
  logic [7:0] read_byte_next;
  logic eng_start_reg;
  logic eng_abort_reg;
  logic [7:0] eng_cmd_reg;
  logic [7:0] eng_param_reg;

  // Toggle crossing; data words are stable long before the edge lands
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tgl_s1_reg <= 1'b0;
      tgl_s2_reg <= 1'b0;
      tgl_s3_reg <= 1'b0;
      lvl_s1_reg <= 1'b0;
      lvl_s2_reg <= 1'b0;
    end else begin
      tgl_s1_reg <= ev_tgl_reg;
      tgl_s2_reg <= tgl_s1_reg;
      tgl_s3_reg <= tgl_s2_reg;
      lvl_s1_reg <= line_level_raw;
      lvl_s2_reg <= lvl_s1_reg;
    end
  end

  // Command decode of a posted event
  wire ev = tgl_s2_reg ^ tgl_s3_reg;
  wire ev_rst = ev && (ev_cmd_reg == CMD_DEV_RESET);
  wire ev_ptr = ev && (ev_cmd_reg == CMD_SET_PTR);
  wire ev_cfg = ev && (ev_cmd_reg == CMD_WR_CFG);
  wire ev_eng = ev && is_engine(ev_cmd_reg);
  wire [3:0] cfg_written = {ev_par_reg[CFG_OVERDRIVE],
                            ev_par_reg[CFG_STRONG], 1'b0,
                            ev_par_reg[CFG_ACTIVE]};
  wire icd_ptr_t ptr_coded = (ev_par_reg == PTR_CODE_DATA) ? ICD_PTR_DATA :
                             (ev_par_reg == PTR_CODE_CFG) ? ICD_PTR_CFG :
                             ICD_PTR_STATUS;

  // Pointer placement; device reset outranks everything
  always_comb begin
    ptr_next = ptr_reg;
    if (ev_rst || ev_eng) begin
      ptr_next = ICD_PTR_STATUS; // RL1 RL8
    end else if (ev_ptr) begin
      ptr_next = ptr_coded; // RL3 RL11
    end else if (ev_cfg) begin
      ptr_next = ICD_PTR_CFG; // RL19
    end
  end

  // Status flag updates from commands and from the engine
  always_comb begin
    status_next = status_reg;
    status_next[ST_LEVEL] = lvl_s2_reg;
    if (ev_rst) begin
      status_next[ST_RST] = 1'b1; // RL6 RL9
      status_next[ST_BUSY] = 1'b0;
      status_next[ST_PRES] = 1'b0;
      status_next[ST_SHORT] = 1'b0;
      status_next[ST_SBR] = 1'b0;
      status_next[ST_TSB] = 1'b0;
      status_next[ST_DIR] = 1'b0;
    end else begin
      if (ev_cfg) begin
        status_next[ST_RST] = 1'b0; // RL19
      end
      if (ev_eng) begin
        status_next[ST_BUSY] = 1'b1; // RL20
      end else if (eng_done) begin
        status_next[ST_BUSY] = 1'b0; // RL20
      end
      if (eng_reset_upd) begin
        status_next[ST_PRES] = eng_presence && !eng_short;
        status_next[ST_SHORT] = eng_short;
      end
      if (eng_bit_upd || eng_trip_upd) begin
        status_next[ST_SBR] = eng_bit;
      end
      if (eng_trip_upd) begin
        status_next[ST_TSB] = eng_trip_second;
        status_next[ST_DIR] = eng_trip_dir;
      end
    end
  end

  // Configuration; a write in the same cycle beats the pullup end
  always_comb begin
    cfg_next = cfg_reg;
    if (ev_rst) begin
      cfg_next = CFG_RESET; // RL10
    end else if (ev_cfg) begin
      cfg_next = cfg_written; // RL14 RL15
    end else if (eng_spu_end) begin
      cfg_next[CFG_STRONG] = 1'b0; // RL21
    end
  end

  // Read-back selection; config upper nibble always zero
  always_comb begin
    unique case (ptr_next)
      ICD_PTR_STATUS: read_byte_next = status_next;
      ICD_PTR_DATA: read_byte_next = data_reg;
      ICD_PTR_CFG: read_byte_next = {CFG_UPPER_READ, cfg_next}; // RL16
      default: read_byte_next = status_next;
    endcase
  end

  // Register file; reset-occurred flag set as after power-on
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ptr_reg <= ICD_PTR_STATUS;
      status_reg <= STATUS_RESET;
      cfg_reg <= CFG_RESET;
      read_byte_reg <= STATUS_RESET;
    end else begin
      ptr_reg <= ptr_next;
      status_reg <= status_next;
      cfg_reg <= cfg_next;
      read_byte_reg <= read_byte_next;
    end
  end

  // Read data byte loaded by the engine
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      data_reg <= 8'h00;
    end else if (eng_data_valid) begin
      data_reg <= eng_data;
    end
  end

  // Engine hand-off; abort leaves one cycle after the reset event
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      eng_start_reg <= 1'b0;
      eng_abort_reg <= 1'b0;
      eng_cmd_reg <= 8'h00;
      eng_param_reg <= 8'h00;
    end else begin
      eng_start_reg <= ev_eng; // RL22
      eng_abort_reg <= ev_rst; // RL4 RL5 RL7
      if (ev_eng) begin
        eng_cmd_reg <= ev_cmd_reg;
        eng_param_reg <= ev_par_reg;
      end
    end
  end

  assign read_ptr = ptr_reg;
  assign read_byte = read_byte_reg;
  assign line_busy_flag = status_reg[ST_BUSY];
  assign overdrive_select = cfg_reg[CFG_OVERDRIVE];
  assign active_pullup_enable = cfg_reg[CFG_ACTIVE];
  assign strong_pullup_enable = cfg_reg[CFG_STRONG];
  assign eng_start = eng_start_reg;
  assign eng_cmd = eng_cmd_reg;
  assign eng_param = eng_param_reg;
  assign eng_abort = eng_abort_reg;

  // ---------------- Checks ----------------
  a_reset_state: assert property (@(posedge mclk) disable iff (!arst_n) // RL6 RL8 RL9 RL10
    ev_rst |-> ##[1:DONE_MAX] (ptr_reg == ICD_PTR_STATUS &&
      status_reg[ST_RST] && !line_busy_flag && cfg_reg == CFG_RESET))
    else $error("device reset did not settle in time");
  a_abort_bound: assert property (@(posedge mclk) disable iff (!arst_n) // RL7
    ev_rst |-> ##[1:STOP_MAX] eng_abort)
    else $error("line abort late after device reset");
  a_cfg_write: assert property (@(posedge mclk) disable iff (!arst_n) // RL18 RL19
    (ev_cfg && !ev_rst) |=> (ptr_reg == ICD_PTR_CFG &&
      !status_reg[ST_RST] && cfg_reg == $past(cfg_written)))
    else $error("configuration write effects missing");
  a_cfg_upper: assert property (@(posedge mclk) disable iff (!arst_n) // RL16
    (ptr_reg == ICD_PTR_CFG) |-> (read_byte[7:4] == CFG_UPPER_READ &&
      read_byte[3:0] == cfg_reg))
    else $error("config read-back upper nibble not zero");
  a_busy_track: assert property (@(posedge mclk) disable iff (!arst_n) // RL1 RL20
    ev_eng |=> (line_busy_flag && eng_start && ptr_reg == ICD_PTR_STATUS)
      ##1 (!eng_start))
    else $error("engine start did not raise busy");
  a_busy_clear: assert property (@(posedge mclk) disable iff (!arst_n) // RL20
    (eng_done && !ev_eng) |=> !line_busy_flag)
    else $error("busy flag stuck after engine done");
  a_spu_end: assert property (@(posedge mclk) disable iff (!arst_n) // RL21
    (eng_spu_end && !ev_cfg) |=> !strong_pullup_enable)
    else $error("strong pullup bit not cleared at end");
  a_ptr_hold: assert property (@(posedge mclk) disable iff (!arst_n) // RL11 RL13
    (ev_ptr && !ev_rst) |=> (ptr_reg == $past(ptr_coded)) &&
      !eng_start && !eng_abort)
    else $error("set-pointer result wrong");
  a_cfg_nibble: assert property (@(negedge link_clk) disable iff (!arst_n) // RL15
    (link_frame && ack_slot && phase_reg == ICD_PH_PARAM &&
     cmd_reg == CMD_WR_CFG && !cfg_byte_ok) |=> sda_oe_n)
    else $error("malformed configuration byte acknowledged");
  a_badptr_nack: assert property (@(negedge link_clk) disable iff (!arst_n) // RL2 RL12
    (link_frame && ack_slot && phase_reg == ICD_PH_PARAM &&
     cmd_reg == CMD_SET_PTR && !ptr_code_ok) |-> !post_now ##1 sda_oe_n)
    else $error("invalid pointer code acknowledged");
  a_busy_nack: assert property (@(negedge link_clk) disable iff (!arst_n) // RL17
    (link_frame && ack_slot && phase_reg == ICD_PH_CODE &&
     shift_reg == CMD_WR_CFG && busy_l2_reg) |=> sda_oe_n)
    else $error("config code acknowledged while busy");

endmodule

//--- icd_host_model.sv
// Host master model driving the command byte stream on the link
`timescale 1ns/10ps
module icd_host_model (
  output logic link_clk,
  output logic link_frame,
  output logic sda_drv,
  input wire logic sda
);
  localparam realtime HALF = 32.0;

  // Link clock idles low and runs inside frames and for the address slot before them; data has a pull-up
  initial begin
    link_clk = 1'b0;
    link_frame = 1'b0;
    sda_drv = 1'b1;
  end

  // One clock pulse; data changes only while the clock is low
  task tick;
    #(HALF) link_clk = 1'b1;
    #(HALF) link_clk = 1'b0;
  endtask

  // Address slot with the frame flag low, then the command frame opens
  task begin_frame;
    tick;
    link_frame = 1'b1;
  endtask

  // Eight data bits MSB first, then the ack slot read at its rising edge
  task put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_drv = b[i];
      tick;
    end
    sda_drv = 1'b1; // Released so the device can pull low
    #(HALF) link_clk = 1'b1;
    ack = (sda === 1'b0);
    #(HALF) link_clk = 1'b0;
  endtask

  // Stop: frame flag drops and the clock stands still
  task end_frame;
    link_frame = 1'b0;
    #(HALF);
  endtask
endmodule

//--- tb_top.sv
// Self-checking bench for the bridge command decoder
`timescale 1ns/10ps
module tb_top;
  import icd_pkg::*;
  logic mclk, arst_n, link_clk, link_frame, sda_drv, sda_wire;
  logic sda_out, sda_oe_n, line_busy_flag, overdrive_select;
  logic active_pullup_enable, strong_pullup_enable;
  icd_ptr_t read_ptr;
  logic [7:0] read_byte, eng_cmd, eng_param, eng_data;
  logic eng_start, eng_abort, eng_done, eng_reset_upd, eng_presence;
  logic eng_short, eng_bit_upd, eng_bit, eng_trip_upd, eng_trip_second;
  logic eng_trip_dir, eng_data_valid, eng_spu_end, line_level_raw;
  int err_total, n_compared, n_abort, n_start;
  realtime t_ack, t_abort, t_rb;
  logic [7:0] ptr_codes [3] = '{PTR_CODE_STATUS, PTR_CODE_DATA, PTR_CODE_CFG};
  // Line codes handed to the decoder; values are arbitrary
  localparam logic [7:0] WRB_CODE = 8'h11;
  localparam logic [7:0] RDB_CODE = 8'h22;
  localparam logic [7:0] TRIP_CODE = 8'h33;

  // Open-drain data wire: pull-up unless someone pulls low
  assign sda_wire = sda_drv & (sda_oe_n ? 1'b1 : sda_out);

  icd_host_model host_u (
    .link_clk(link_clk),
    .link_frame(link_frame),
    .sda_drv(sda_drv),
    .sda(sda_wire)
  );

  icd_cmd_decoder #(
    .CODE_WR_BYTE(WRB_CODE),
    .CODE_RD_BYTE(RDB_CODE),
    .CODE_TRIPLET(TRIP_CODE)
  ) dut_u (
    .mclk(mclk), .arst_n(arst_n), .link_clk(link_clk),
    .link_frame(link_frame), .link_bit(sda_wire),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .read_ptr(read_ptr),
    .read_byte(read_byte), .line_busy_flag(line_busy_flag),
    .overdrive_select(overdrive_select),
    .active_pullup_enable(active_pullup_enable),
    .strong_pullup_enable(strong_pullup_enable),
    .eng_start(eng_start), .eng_cmd(eng_cmd), .eng_param(eng_param),
    .eng_abort(eng_abort), .eng_done(eng_done),
    .eng_reset_upd(eng_reset_upd), .eng_presence(eng_presence),
    .eng_short(eng_short), .eng_bit_upd(eng_bit_upd), .eng_bit(eng_bit),
    .eng_trip_upd(eng_trip_upd), .eng_trip_second(eng_trip_second),
    .eng_trip_dir(eng_trip_dir), .eng_data_valid(eng_data_valid),
    .eng_data(eng_data), .eng_spu_end(eng_spu_end),
    .line_level_raw(line_level_raw)
  );

  // System clock, 100 ns period
  initial mclk = 1'b0;
  always #50 mclk = ~mclk;

  // Time stamps for the reset timing bounds
  always @(posedge eng_abort) begin
    n_abort++;
    t_abort = $realtime;
  end
  always @(read_byte) t_rb = $realtime;
  always @(posedge eng_start) n_start++;

  task stop_test;
    if (err_total == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Posted commands land a few mclk after the ack; six covers it
  task settle;
    repeat (6) @(posedge mclk);
    #1;
  endtask

  // One engine strobe cycle: {spu_end,data_valid,trip,bit,reset,done}
  task pulse(input logic [5:0] s);
    @(posedge mclk);
    #1;
    {eng_spu_end, eng_data_valid, eng_trip_upd} = s[5:3];
    {eng_bit_upd, eng_reset_upd, eng_done} = s[2:0];
    @(posedge mclk);
    #1;
    {eng_spu_end, eng_data_valid, eng_trip_upd} = 3'b000;
    {eng_bit_upd, eng_reset_upd, eng_done} = 3'b000;
  endtask

  // Code byte, optional parameter, then compare both acks
  task cmd(input logic [7:0] c, input logic [7:0] p, input bit two,
           input logic [1:0] exp);
    logic a0, a1;
    a1 = 1'b0;
    host_u.begin_frame;
    host_u.put_byte(c, a0);
    t_ack = $realtime;
    if (two)
      host_u.put_byte(p, a1);
    host_u.end_frame;
    check({6'h00, a0, a1}, {6'h00, exp});
    settle;
  endtask

  // Hang guard, far beyond the few tens of microseconds needed
  initial begin
    #1_000_000;
    err_total++;
    stop_test;
  end

  // Main sequence
  initial begin
    arst_n = 1'b0;
    {eng_done, eng_reset_upd, eng_presence, eng_short} = 4'h0;
    {eng_bit_upd, eng_bit, eng_trip_upd, eng_trip_second} = 4'h0;
    {eng_trip_dir, eng_data_valid, eng_spu_end, line_level_raw} = 4'h0;
    eng_data = 8'h00;
    err_total = 0;
    n_compared = 0;
    n_abort = 0;
    n_start = 0;
    repeat (5) @(posedge mclk);
    #1 arst_n = 1'b1;
    settle;
    check(read_byte, 8'h10);
    check({6'h00, read_ptr}, 8'h00);
    // Valid configuration byte, then one with a bad upper nibble
    cmd(CMD_WR_CFG, 8'h2D, 1'b1, 2'b11);
    check({6'h00, read_ptr}, 8'h02);
    check(read_byte, 8'h0D);
    check({5'h00, overdrive_select, strong_pullup_enable,
           active_pullup_enable}, 8'h07);
    cmd(CMD_WR_CFG, 8'h3D, 1'b1, 2'b10);
    check(read_byte, 8'h0D);
    // Strong pullup period ends in the engine
    pulse(6'b100000);
    check({7'h00, strong_pullup_enable}, 8'h00);
    check(read_byte, 8'h09);
    // Read data load, then every pointer code in turn
    eng_data = 8'hA5;
    pulse(6'b010000);
    for (int i = 0; i < 3; i++) begin
      cmd(CMD_SET_PTR, ptr_codes[i], 1'b1, 2'b11);
      check({6'h00, read_ptr}, i[7:0]);
    end
    cmd(CMD_SET_PTR, PTR_CODE_DATA, 1'b1, 2'b11);
    check(read_byte, 8'hA5);
    cmd(CMD_SET_PTR, 8'h55, 1'b1, 2'b10);
    check({6'h00, read_ptr}, 8'h01);
    // Line reset: start to engine, pointer to status, busy set
    cmd(CMD_LINE_RESET, 8'h00, 1'b0, 2'b10);
    check(eng_cmd, CMD_LINE_RESET);
    check({6'h00, read_ptr}, 8'h00);
    check(read_byte, 8'h01);
    check({7'h00, line_busy_flag}, 8'h01);
    cmd(CMD_WR_CFG, 8'h1E, 1'b1, 2'b00);
    check({5'h00, overdrive_select, strong_pullup_enable,
           active_pullup_enable}, 8'h05);
    // Presence result, then completion clears busy
    eng_presence = 1'b1;
    pulse(6'b000010);
    pulse(6'b000001);
    check(read_byte, 8'h02);
    // Single bit command with parameter, results from the engine
    cmd(CMD_LINE_BIT, 8'h80, 1'b1, 2'b11);
    check(eng_param, 8'h80);
    {eng_bit, eng_trip_second, eng_trip_dir} = 3'b111;
    pulse(6'b000100);
    pulse(6'b001000);
    check(read_byte, 8'hE3);
    // Triplet and read byte codes once the engine has finished
    pulse(6'b000001);
    cmd(TRIP_CODE, 8'h40, 1'b1, 2'b11);
    check(eng_cmd, TRIP_CODE);
    check(eng_param, 8'h40);
    pulse(6'b000001);
    cmd(RDB_CODE, 8'h00, 1'b0, 2'b10);
    check(eng_cmd, RDB_CODE);
    check(read_byte, 8'hE3);
    // Device reset while the line is busy
    cmd(CMD_DEV_RESET, 8'h00, 1'b0, 2'b10);
    check(n_abort[7:0], 8'h01);
    check({7'h00, (t_abort - t_ack <= 262.5)}, 8'h01);
    check({7'h00, (t_rb - t_ack <= 525.0)}, 8'h01);
    check(read_byte, 8'h10);
    check({6'h00, read_ptr}, 8'h00);
    check({5'h00, overdrive_select, strong_pullup_enable,
           active_pullup_enable}, 8'h00);
    check({7'h00, eng_abort}, 8'h00);
    check(n_start[7:0], 8'h04);
    stop_test;
  end
endmodule
